// ### common/alm_pkg.sv
// constants, thresholds and types for the audio level meter bank
package alm_pkg;

    // clock and display refresh
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned REFRESH_MS   = 50;
    localparam int unsigned REFRESH_CYC  = (CLK_HZ / 1000) * REFRESH_MS;

    // meter map
    localparam int unsigned NUM_METERS   = 50;
    localparam int unsigned MIDX_W       = 6;
    localparam int unsigned CNT_W        = 4;
    localparam int unsigned NUM_THR      = 11;
    localparam int unsigned MAIN_SEGS    = 12;
    localparam logic [5:0]  M_IN_LO      = 6'h00;  // inputs 1-16
    localparam logic [5:0]  M_FX_RTN     = 6'h10;  // effects returns 1-2
    localparam logic [5:0]  M_ST_L       = 6'h12;  // stereo out, wide scale
    localparam logic [5:0]  M_ST_R       = 6'h13;
    localparam logic [5:0]  M_AUX        = 6'h14;  // aux sends 1-4
    localparam logic [5:0]  M_BUS        = 6'h18;  // bus outs 1-4
    localparam logic [5:0]  M_MAIN_L     = 6'h1C;  // dedicated stereo meter
    localparam logic [5:0]  M_MAIN_R     = 6'h1D;
    localparam logic [5:0]  M_OMNI       = 6'h1E;  // omni outs 1-4
    localparam logic [5:0]  M_IN_HI      = 6'h22;  // inputs 17-24
    localparam logic [5:0]  M_OPT_OUT    = 6'h2A;  // expansion outputs 1-8
    localparam logic [5:0]  M_END        = 6'h32;

    // audio magnitude levels, full scale 24-bit
    localparam logic [23:0] CLIP_LEVEL   = 24'h7FFFFF;
    localparam logic [23:0] THR_NONE     = 24'hFFFFFF;
    localparam logic [23:0] THR_MAIN [0:10] = '{
        24'h008274, 24'h010449, 24'h020757, 24'h040C37, 24'h081385, 24'h101D3F,
        24'h16C320, 24'h2026F8, 24'h2D6A12, 24'h402603, 24'h5A9E52};
    localparam logic [23:0] THR_EXT [0:10] = '{
        24'h00083B, 24'h0020C5, 24'h010449, 24'h040C37, 24'h101D3F, 24'h2026F8,
        24'h32F540, 24'h50C331, THR_NONE, THR_NONE, THR_NONE};
    localparam logic [23:0] THR_GEN [0:10] = '{
        24'h008274, 24'h040C37, 24'h101D3F, 24'h2026F8, 24'h402603, THR_NONE,
        THR_NONE, THR_NONE, THR_NONE, THR_NONE, THR_NONE};

    // register map
    localparam logic [11:0] REG_CTRL     = 12'h000;
    localparam logic [11:0] REG_METER    = 12'h100;
    localparam int unsigned CTRL_HOLD    = 0;
    localparam int unsigned CTRL_IN_TAP  = 1;
    localparam int unsigned CTRL_OUT_TAP = 2;
    localparam logic [2:0]  CTRL_RESET   = 3'h0;
    localparam int unsigned MR_CUR_LSB   = 0;
    localparam int unsigned MR_HELD_LSB  = 4;
    localparam int unsigned MR_CLIP      = 8;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        BEFORE_EQUALIZER_TAP,
        BEFORE_FADER_TAP,
        AFTER_EQUALIZER_TAP,
        AFTER_ON_TAP
    } alm_tap_type;

    typedef enum logic [1:0] {
        SCALE_GENERAL,
        SCALE_WIDE,
        SCALE_MAIN
    } alm_scale_type;

endpackage

// ### rtl/alm_seg_conv.sv
// peak magnitude to lit segment count for one meter scale
`timescale 1ns/10ps
`default_nettype none

module alm_seg_conv
(
    input  wire logic [23:0]                mag,
    input  wire alm_pkg::alm_scale_type     scale,
    output logic      [3:0]                 seg_cnt,
    output logic                            clip
);

    logic [alm_pkg::NUM_THR-1:0] hit;

    assign clip = (mag >= alm_pkg::CLIP_LEVEL);

    genvar k;
    generate
        for (k = 0; k < alm_pkg::NUM_THR; k++)
        begin : g_thr
            always_comb
            begin
                case (scale)
                    alm_pkg::SCALE_MAIN:
                        hit[k] = (mag >= alm_pkg::THR_MAIN[k]);
                    alm_pkg::SCALE_WIDE:
                        hit[k] = (mag >= alm_pkg::THR_EXT[k]);
                    default:
                        hit[k] = (mag >= alm_pkg::THR_GEN[k]);
                endcase
            end
        end
    endgenerate

    // thresholds ascend, so the hits form a thermometer; top segment is clip
    always_comb
    begin
        logic [3:0] n;
        n = {3'h0, clip};
        for (int i = 0; i < alm_pkg::NUM_THR; i++)
        begin
            n = n + {3'h0, hit[i]};
        end
        seg_cnt = n;
    end

endmodule

`default_nettype wire

// ### rtl/alm_meter_bank.sv
// audio level meter bank with tap selection, peak hold and register access
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module alm_meter_bank
#(
    parameter int unsigned REFRESH_CYCLES = alm_pkg::REFRESH_CYC
)
(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       smp_valid,
    input  wire logic [5:0]                 smp_meter,
    input  wire alm_pkg::alm_tap_type       smp_tap,
    input  wire logic [23:0]                smp_data,
    output logic      [11:0]                main_seg_l_ff,
    output logic      [11:0]                main_seg_r_ff,
    input  wire logic [11:0]                s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic      [1:0]                 s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [11:0]                s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic      [31:0]                s_axi_rdata,
    output logic      [1:0]                 s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);

    localparam int unsigned N = alm_pkg::NUM_METERS;

    logic [2:0]     ctrl_ff;
    logic [23:0]    acc_ff  [0:N-1];
    logic [3:0]     cur_ff  [0:N-1];
    logic [3:0]     held_ff [0:N-1];
    logic           clip_ff [0:N-1];
    logic [31:0]    tick_cnt_ff;
    logic           scan_busy_ff;
    logic [5:0]     scan_idx_ff;
    logic           hold_on;
    logic           tick;
    logic           smp_take;
    logic [23:0]    smp_mag;
    logic [23:0]    scan_mag;
    logic [3:0]     conv_cnt;
    logic           conv_clip;
    logic [3:0]     nxt_held;
    alm_pkg::alm_scale_type scan_scale;

    ////////////////////////////////////////////////////////////////////////
    // tap selection and sample capture

    assign hold_on = ctrl_ff[alm_pkg::CTRL_HOLD];

    function automatic logic tap_ok(input logic [5:0] m, input alm_pkg::alm_tap_type t,
                                    input logic [2:0] c);
        if (m < alm_pkg::M_ST_L)
            tap_ok = (t == (c[alm_pkg::CTRL_IN_TAP] ? alm_pkg::BEFORE_FADER_TAP
                                                    : alm_pkg::BEFORE_EQUALIZER_TAP));
        else if (m < alm_pkg::M_MAIN_L)
            tap_ok = (t == (c[alm_pkg::CTRL_OUT_TAP] ? alm_pkg::AFTER_ON_TAP
                                                     : alm_pkg::AFTER_EQUALIZER_TAP));
        else if (m < alm_pkg::M_OMNI)
            tap_ok = (t == alm_pkg::AFTER_ON_TAP);
        else
            tap_ok = (m < alm_pkg::M_END);
    endfunction

    function automatic alm_pkg::alm_scale_type scale_of(input logic [5:0] m);
        if (m == alm_pkg::M_MAIN_L || m == alm_pkg::M_MAIN_R)
            scale_of = alm_pkg::SCALE_MAIN;
        else if (m == alm_pkg::M_ST_L || m == alm_pkg::M_ST_R)
            scale_of = alm_pkg::SCALE_WIDE;
        else
            scale_of = alm_pkg::SCALE_GENERAL;
    endfunction

    assign smp_take = smp_valid && tap_ok(smp_meter, smp_tap, ctrl_ff);
    assign smp_mag  = smp_data[23] ? 24'(-smp_data) : smp_data;

    // running absolute peak; a meter being scanned restarts from this sample
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < N; i++)
                acc_ff[i] <= 24'h000000;
        end
        else
        begin
            if (scan_busy_ff)
                acc_ff[scan_idx_ff] <= 24'h000000;
            if (smp_take)
            begin
                if (scan_busy_ff && smp_meter == scan_idx_ff)
                    acc_ff[smp_meter] <= smp_mag;
                else if (smp_mag > acc_ff[smp_meter])
                    acc_ff[smp_meter] <= smp_mag;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // refresh interval and meter scan

    assign tick = (tick_cnt_ff == 32'(REFRESH_CYCLES - 1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tick_cnt_ff <= 32'h00000000;
        else if (tick)
            tick_cnt_ff <= 32'h00000000;
        else
            tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            scan_busy_ff <= 1'b0;
            scan_idx_ff  <= 6'h00;
        end
        else if (tick)
        begin
            scan_busy_ff <= 1'b1;
            scan_idx_ff  <= 6'h00;
        end
        else if (scan_busy_ff)
        begin
            scan_busy_ff <= (scan_idx_ff != alm_pkg::M_END - 6'h01);
            scan_idx_ff  <= scan_idx_ff + 6'h01;
        end
    end

    assign scan_mag   = acc_ff[scan_idx_ff];
    assign scan_scale = scale_of(scan_idx_ff);

    alm_seg_conv u_conv
    (
        .mag        (scan_mag),
        .scale      (scan_scale),
        .seg_cnt    (conv_cnt),
        .clip       (conv_clip)
    );

    // hold on: keep the larger; hold off: follow, so a re-enable starts fresh
    assign nxt_held = (hold_on && held_ff[scan_idx_ff] > conv_cnt)
                    ? held_ff[scan_idx_ff] : conv_cnt;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < N; i++)
            begin
                cur_ff[i]  <= 4'h0;
                held_ff[i] <= 4'h0;
                clip_ff[i] <= 1'b0;
            end
        end
        else
        begin
            // hold off: held tracks current, so any off/on restarts from here
            if (!hold_on)
            begin
                for (int i = 0; i < N; i++)
                    held_ff[i] <= cur_ff[i];
            end
            if (scan_busy_ff)
            begin
                cur_ff[scan_idx_ff]  <= conv_cnt;
                held_ff[scan_idx_ff] <= nxt_held;
                clip_ff[scan_idx_ff] <= conv_clip;
            end
        end
    end

    // dedicated stereo bar graph, thermometer coded
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            main_seg_l_ff <= 12'h000;
            main_seg_r_ff <= 12'h000;
        end
        else
        begin
            for (int s = 0; s < alm_pkg::MAIN_SEGS; s++)
            begin
                if (!hold_on)
                begin
                    main_seg_l_ff[s] <= (cur_ff[alm_pkg::M_MAIN_L] > 4'(s));
                    main_seg_r_ff[s] <= (cur_ff[alm_pkg::M_MAIN_R] > 4'(s));
                end
                if (scan_busy_ff && scan_idx_ff == alm_pkg::M_MAIN_L)
                    main_seg_l_ff[s] <= (nxt_held > 4'(s));
                if (scan_busy_ff && scan_idx_ff == alm_pkg::M_MAIN_R)
                    main_seg_r_ff[s] <= (nxt_held > 4'(s));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register bus

    logic           aw_held_ff;
    logic           w_held_ff;
    logic [11:0]    aw_addr_ff;
    logic [31:0]    w_data_ff;
    logic [3:0]     w_strb_ff;
    logic [11:0]    rd_off;
    logic [5:0]     rd_idx;

    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff   <= 1'b0;
            w_held_ff    <= 1'b0;
            aw_addr_ff   <= 12'h000;
            w_data_ff    <= 32'h00000000;
            w_strb_ff    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= alm_pkg::RESP_OKAY;
            ctrl_ff      <= alm_pkg::CTRL_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (aw_held_ff && w_held_ff)
            begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if ({aw_addr_ff[11:2], 2'h0} == alm_pkg::REG_CTRL)
                begin
                    s_axi_bresp <= alm_pkg::RESP_OKAY;
                    if (w_strb_ff[0])
                        ctrl_ff <= w_data_ff[2:0];
                end
                else
                    s_axi_bresp <= alm_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign rd_off = s_axi_araddr - alm_pkg::REG_METER;
    assign rd_idx = rd_off[7:2];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= alm_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= alm_pkg::RESP_OKAY;
            if ({s_axi_araddr[11:2], 2'h0} == alm_pkg::REG_CTRL)
                s_axi_rdata[2:0] <= ctrl_ff;
            else if (s_axi_araddr >= alm_pkg::REG_METER && rd_off[11:8] == 4'h0
                     && rd_idx < alm_pkg::M_END)
            begin
                s_axi_rdata[alm_pkg::MR_CUR_LSB +: 4]  <= cur_ff[rd_idx];
                s_axi_rdata[alm_pkg::MR_HELD_LSB +: 4] <= held_ff[rd_idx];
                s_axi_rdata[alm_pkg::MR_CLIP]          <= clip_ff[rd_idx];
            end
            else
                s_axi_rresp <= alm_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_clip_lights: assert property (@(posedge aclk) disable iff (!aresetn)
        scan_busy_ff && scan_mag >= alm_pkg::CLIP_LEVEL |=> clip_ff[$past(scan_idx_ff)])
        else $error("clip not flagged on full scale peak");

    a_hold_global: assert property (@(posedge aclk) disable iff (!aresetn)
        scan_busy_ff && hold_on && held_ff[scan_idx_ff] > conv_cnt
        |=> held_ff[$past(scan_idx_ff)] == $past(held_ff[scan_idx_ff]))
        else $error("held level dropped while hold enabled");

    a_hold_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
        hold_on && $past(hold_on) |-> main_seg_l_ff >= $past(main_seg_l_ff))
        else $error("main meter fell while holding");

    a_hold_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        scan_busy_ff && !hold_on |=> held_ff[$past(scan_idx_ff)] == $past(conv_cnt))
        else $error("held level not reset while hold off");

    a_main_floor: assert property (@(posedge aclk) disable iff (!aresetn)
        scan_busy_ff && scan_idx_ff == alm_pkg::M_MAIN_L && !hold_on
        && scan_mag < alm_pkg::THR_MAIN[0] |=> main_seg_l_ff == 12'h000)
        else $error("main meter lit below its floor");

    a_wide_floor: assert property (@(posedge aclk) disable iff (!aresetn)
        scan_busy_ff && scan_idx_ff == alm_pkg::M_ST_L && scan_mag >= alm_pkg::THR_EXT[0]
        |-> conv_cnt != 4'h0)
        else $error("wide stereo meter dark above its floor");

    a_input_tap: assert property (@(posedge aclk) disable iff (!aresetn)
        smp_take && smp_meter < alm_pkg::M_ST_L |-> (smp_tap == alm_pkg::BEFORE_FADER_TAP)
        == ctrl_ff[alm_pkg::CTRL_IN_TAP])
        else $error("input meter took wrong tap");

    a_output_tap: assert property (@(posedge aclk) disable iff (!aresetn)
        smp_take && smp_meter >= alm_pkg::M_ST_L && smp_meter < alm_pkg::M_MAIN_L
        |-> (smp_tap == alm_pkg::AFTER_ON_TAP) == ctrl_ff[alm_pkg::CTRL_OUT_TAP])
        else $error("output meter took wrong tap");

    a_main_tap: assert property (@(posedge aclk) disable iff (!aresetn)
        smp_take && (smp_meter == alm_pkg::M_MAIN_L || smp_meter == alm_pkg::M_MAIN_R)
        |-> smp_tap == alm_pkg::AFTER_ON_TAP)
        else $error("main meter took a selectable tap");

    a_free_meters: assert property (@(posedge aclk) disable iff (!aresetn)
        smp_valid && smp_meter >= alm_pkg::M_IN_HI && smp_meter < alm_pkg::M_END |-> smp_take)
        else $error("expansion or upper input sample dropped");

    a_omni_take: assert property (@(posedge aclk) disable iff (!aresetn)
        smp_valid && smp_meter >= alm_pkg::M_OMNI && smp_meter < alm_pkg::M_IN_HI |-> smp_take)
        else $error("omni sample dropped");

    a_scan_len: assert property (@(posedge aclk) disable iff (!aresetn)
        tick |=> (scan_busy_ff && scan_idx_ff == 6'h00)
        ##49 (scan_busy_ff && scan_idx_ff == alm_pkg::M_END - 6'h01) ##1 !scan_busy_ff)
        else $error("scan did not cover every meter once");

endmodule

`default_nettype wire

// ### dv/alm_datapath_model.sv
// stand-in for the mixing datapath: streams one tapped sample per clock
`timescale 1ns/10ps
`default_nettype none

module alm_datapath_model
(
    input  wire logic                   aclk,
    input  wire logic                   run,
    input  wire logic [5:0]             meter,
    input  wire alm_pkg::alm_tap_type   tap,
    input  wire logic [23:0]            level,
    output logic                        smp_valid,
    output logic      [5:0]             smp_meter,
    output alm_pkg::alm_tap_type        smp_tap,
    output logic      [23:0]            smp_data
);
    logic neg_ff;

    initial
    begin
        neg_ff = 1'b0;
        smp_valid = 1'b0;
        smp_meter = 6'h3F;
        smp_tap = alm_pkg::BEFORE_EQUALIZER_TAP;
        smp_data = 24'h000000;
    end

    // alternate sign so only the magnitude can light the meter; idle data keeps toggling
    always @(posedge aclk)
    begin
        neg_ff <= run ? !neg_ff : 1'b0;
        smp_valid <= run;
        smp_meter <= meter;
        smp_tap <= tap;
        smp_data <= run ? (neg_ff ? -level : level) : ~smp_data;
    end
endmodule
`default_nettype wire

// ### dv/tb_audio_level_meter_bank.sv
// self-checking bench for the meter bank: taps, scales, clip and peak hold
`timescale 1ns/10ps
`default_nettype none

module tb_audio_level_meter_bank;
    localparam int REFRESH = 200;
    localparam int TIMEOUT = 20000;
    logic aclk;
    logic aresetn = 1'b0;
    logic st_run = 1'b0;
    logic [5:0] st_meter = 6'h00;
    alm_pkg::alm_tap_type st_tap = alm_pkg::BEFORE_EQUALIZER_TAP;
    logic [23:0] st_level = 24'h000000;
    logic smp_valid;
    logic [5:0] smp_meter;
    alm_pkg::alm_tap_type smp_tap;
    logic [23:0] smp_data;
    logic [11:0] main_seg_l;
    logic [11:0] main_seg_r;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int bad_count = 0;
    int checks_done = 0;
    int cyc_count = 0;

    alm_datapath_model partner (.aclk(aclk), .run(st_run), .meter(st_meter), .tap(st_tap),
        .level(st_level), .smp_valid(smp_valid), .smp_meter(smp_meter), .smp_tap(smp_tap),
        .smp_data(smp_data));

    alm_meter_bank #(.REFRESH_CYCLES(REFRESH)) DUT (.aclk(aclk), .aresetn(aresetn),
        .smp_valid(smp_valid), .smp_meter(smp_meter), .smp_tap(smp_tap), .smp_data(smp_data),
        .main_seg_l_ff(main_seg_l), .main_seg_r_ff(main_seg_r),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // bus write, response code compared with the expected one
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, er}, "write resp");
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        chk(s_axi_rdata, ed, "read data");
        chk({30'h0, s_axi_rresp}, {30'h0, er}, "read resp");
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    function automatic logic [11:0] mreg(input logic [5:0] m);
        return alm_pkg::REG_METER + {4'h0, m, 2'h0};
    endfunction

    // stream one meter long enough for two full scans
    task automatic stream(input logic [5:0] m, input alm_pkg::alm_tap_type t,
                          input logic [23:0] lv);
        st_meter <= m;
        st_tap <= t;
        st_level <= lv;
        st_run <= 1'b1;
        repeat (2 * REFRESH + 110) @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({20'h0, main_seg_l}, 32'h0, "main left idle");
        rd_chk(alm_pkg::REG_CTRL, 32'h0, alm_pkg::RESP_OKAY);
        rd_chk(mreg(6'd50), 32'h0, alm_pkg::RESP_SLVERR);
        wr(mreg(6'd0), 32'hFFFFFFFF, alm_pkg::RESP_SLVERR);
        rd_chk(mreg(6'd0), 32'h0, alm_pkg::RESP_OKAY);
    endtask

    task automatic t_general;
        stream(6'd0, alm_pkg::BEFORE_EQUALIZER_TAP, 24'h040C37);
        rd_chk(mreg(6'd0), 32'h022, alm_pkg::RESP_OKAY);
        stream(6'd0, alm_pkg::BEFORE_EQUALIZER_TAP, 24'h7FFFFF);
        rd_chk(mreg(6'd0), 32'h166, alm_pkg::RESP_OKAY);
    endtask

    task automatic t_main;
        stream(6'd28, alm_pkg::AFTER_ON_TAP, 24'h7FFFFF);
        chk({20'h0, main_seg_l}, 32'hFFF, "main left full");
        chk({20'h0, main_seg_r}, 32'h000, "main right quiet");
        rd_chk(mreg(6'd28), 32'h1CC, alm_pkg::RESP_OKAY);
        stream(6'd29, alm_pkg::AFTER_ON_TAP, 24'h008274);
        chk({20'h0, main_seg_r}, 32'h001, "main right bottom");
        stream(6'd28, alm_pkg::AFTER_EQUALIZER_TAP, 24'h7FFFFF);
        chk({20'h0, main_seg_l}, 32'h000, "main left wrong tap");
    endtask

    task automatic t_wide;
        stream(6'd18, alm_pkg::AFTER_EQUALIZER_TAP, 24'h50C331);
        rd_chk(mreg(6'd18), 32'h088, alm_pkg::RESP_OKAY);
        stream(6'd19, alm_pkg::AFTER_EQUALIZER_TAP, 24'h00083B);
        rd_chk(mreg(6'd19), 32'h011, alm_pkg::RESP_OKAY);
    endtask

    task automatic t_taps;
        wr(alm_pkg::REG_CTRL, 32'h6, alm_pkg::RESP_OKAY);
        rd_chk(alm_pkg::REG_CTRL, 32'h6, alm_pkg::RESP_OKAY);
        stream(6'd0, alm_pkg::BEFORE_EQUALIZER_TAP, 24'h7FFFFF);
        rd_chk(mreg(6'd0), 32'h0, alm_pkg::RESP_OKAY);
        stream(6'd16, alm_pkg::BEFORE_FADER_TAP, 24'h7FFFFF);
        rd_chk(mreg(6'd16), 32'h166, alm_pkg::RESP_OKAY);
        stream(6'd20, alm_pkg::AFTER_EQUALIZER_TAP, 24'h7FFFFF);
        rd_chk(mreg(6'd20), 32'h0, alm_pkg::RESP_OKAY);
        stream(6'd24, alm_pkg::AFTER_ON_TAP, 24'h101D3F);
        rd_chk(mreg(6'd24), 32'h033, alm_pkg::RESP_OKAY);
        stream(6'd28, alm_pkg::AFTER_ON_TAP, 24'h7FFFFF);
        chk({20'h0, main_seg_l}, 32'hFFF, "main left after taps");
        wr(alm_pkg::REG_CTRL, 32'h0, alm_pkg::RESP_OKAY);
    endtask

    task automatic t_others;
        logic [5:0] ids [6] = '{6'd30, 6'd33, 6'd34, 6'd41, 6'd42, 6'd49};
        foreach (ids[i])
        begin
            stream(ids[i], alm_pkg::alm_tap_type'(i % 4), 24'h7FFFFF);
            rd_chk(mreg(ids[i]), 32'h166, alm_pkg::RESP_OKAY);
        end
    endtask

    task automatic t_hold;
        wr(alm_pkg::REG_CTRL, 32'h1, alm_pkg::RESP_OKAY);
        stream(6'd28, alm_pkg::AFTER_ON_TAP, 24'h7FFFFF);
        stream(6'd28, alm_pkg::AFTER_ON_TAP, 24'h008274);
        chk({20'h0, main_seg_l}, 32'hFFF, "main left held");
        rd_chk(mreg(6'd28), 32'h0C1, alm_pkg::RESP_OKAY);
        stream(6'd0, alm_pkg::BEFORE_EQUALIZER_TAP, 24'h7FFFFF);
        stream(6'd0, alm_pkg::BEFORE_EQUALIZER_TAP, 24'h040C37);
        rd_chk(mreg(6'd0), 32'h062, alm_pkg::RESP_OKAY);
        wr(alm_pkg::REG_CTRL, 32'h0, alm_pkg::RESP_OKAY);
        wr(alm_pkg::REG_CTRL, 32'h1, alm_pkg::RESP_OKAY);
        stream(6'd0, alm_pkg::BEFORE_EQUALIZER_TAP, 24'h040C37);
        rd_chk(mreg(6'd0), 32'h022, alm_pkg::RESP_OKAY);
        chk({20'h0, main_seg_l}, 32'h000, "main left restarted");
        wr(alm_pkg::REG_CTRL, 32'h0, alm_pkg::RESP_OKAY);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cyc_count++;
        if (cyc_count == TIMEOUT)
        begin
            bad_count++;
            end_of_test;
        end
    end

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_general;
        t_main;
        t_wide;
        t_taps;
        t_others;
        t_hold;
        end_of_test;
    end
endmodule
`default_nettype wire
